// File: hw/sfm_pkg.sv
package sfm_pkg;
  // Page geometry for the two page-size modes and the array size.
  localparam int PAGE_STD        = 264;
  localparam int PAGE_BIN        = 256;
  localparam int NUM_PAGES       = 4096;
  localparam int FLAT_W          = 21;
  localparam int HDR_BYTES       = 4;
  // Command opcodes and the value of an erased byte.
  localparam logic [7:0] OP_RMW_B1       = 8'h58;
  localparam logic [7:0] OP_RMW_B2       = 8'h59;
  localparam logic [7:0] OP_PAGE_ERASE   = 8'h81;
  localparam logic [7:0] OP_BLOCK_ERASE  = 8'h50;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h7c;
  localparam logic [7:0] ERASED_BYTE     = 8'hff;
  // Erase granularity: block mask and the split of sector zero.
  localparam logic [11:0] BLOCK_MASK     = 12'hff8;
  localparam logic [11:0] SMALL0A_LAST   = 12'h007;
  localparam logic [11:0] SMALL0B_FIRST  = 12'h008;
  localparam logic [11:0] SECTOR_SPAN    = 12'h0ff;
  // Self-timed limits in microseconds and their core clock counts.
  localparam int CLK_PERIOD_NS             = 25;
  localparam int PROGRAM_TIME_LIMIT_US     = 4000;
  localparam int PAGE_ERASE_TIME_LIMIT_US  = 35000;
  localparam int BLOCK_ERASE_TIME_LIMIT_US = 50000;
  localparam int SECTOR_ERASE_TIME_LIMIT_US = 2000000;
  localparam int PROG_LIMIT_CYC  = PROGRAM_TIME_LIMIT_US * 1000 / CLK_PERIOD_NS;
  localparam int PE_LIMIT_CYC    = PAGE_ERASE_TIME_LIMIT_US * 1000 / CLK_PERIOD_NS;
  localparam int BE_LIMIT_CYC    = BLOCK_ERASE_TIME_LIMIT_US * 1000 / CLK_PERIOD_NS;
  localparam int SE_LIMIT_CYC    = SECTOR_ERASE_TIME_LIMIT_US * 1000 / CLK_PERIOD_NS;
  // Host side: core cycles chip select stays high after a frame.
  localparam logic [4:0] CS_HIGH_CYC = 5'd16;
endpackage : sfm_pkg

// File: hw/sfm_link_if.sv
`timescale 1ns/10ps
interface sfm_link_if;
  logic sck;
  logic cs_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic busy;

  // The flash end receives the serial frame and reports busy.
  modport dev (
    input  sck,
    input  cs_n,
    input  mosi,
    output miso,
    output miso_oe,
    output busy
  );

  // The controller end makes the clock and the frame.
  modport host (
    output sck,
    output cs_n,
    output mosi,
    input  miso,
    input  miso_oe,
    input  busy
  );
endinterface : sfm_link_if

// File: hw/sfm_dev.sv
`timescale 1ns/10ps
module sfm_dev #(
  parameter int PROG_LIMIT = sfm_pkg::PROG_LIMIT_CYC,
  parameter int PE_LIMIT   = sfm_pkg::PE_LIMIT_CYC,
  parameter int BE_LIMIT   = sfm_pkg::BE_LIMIT_CYC,
  parameter int SE_LIMIT   = sfm_pkg::SE_LIMIT_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  sfm_link_if.dev          link,
  input  wire logic        binary_pages,
  input  wire logic        fault_en,
  input  wire logic [11:0] fault_page,
  output logic             ready_busy,
  output logic             erase_program_fail_flag
);
  import sfm_pkg::*;

  typedef enum logic [2:0] {
    SFM_IDLE  = 3'b000,
    SFM_LOAD  = 3'b001,
    SFM_MERGE = 3'b011,
    SFM_PROG  = 3'b010,
    SFM_ERASE = 3'b110,
    SFM_DONE  = 3'b100
  } sfm_state_e;

  if (PROG_LIMIT < 1 || PE_LIMIT < 1 || BE_LIMIT < 1 || SE_LIMIT < 1) begin : g_chk
    $error("sfm_dev: time limits must be at least one cycle");
  end

  // Byte position of a page byte inside the flat main array.
  function automatic logic [FLAT_W-1:0] flat(input logic [11:0] pg, input logic [8:0] b);
    flat = FLAT_W'(pg) * FLAT_W'(PAGE_STD) + FLAT_W'(b);
  endfunction : flat

  // ---------------- Link clock domain ----------------
  logic                 fresh;
  logic                 bin_s1;
  logic                 bin_s2;
  logic [2:0]           phase;
  logic [2:0]           hdr;
  logic [6:0]           shreg;
  logic [7:0]           opcode;
  logic [23:0]          addr;
  logic                 have_data;
  logic [8:0]           ptr;
  logic [PAGE_STD-1:0]  rx_mask;
  logic [7:0]           rx_buf [2][PAGE_STD];

  wire  [2:0] cur_phase = fresh ? 3'd0 : phase;
  wire  [2:0] cur_hdr   = fresh ? 3'd0 : hdr;
  wire  [7:0] byte_in   = {shreg, link.mosi};
  wire        byte_end  = (cur_phase == 3'd7);
  wire        data_end  = byte_end && (cur_hdr == 3'(HDR_BYTES));
  wire  [8:0] sck_last  = bin_s2 ? 9'(PAGE_BIN - 1) : 9'(PAGE_STD - 1);

  // Chip select high marks the next link edge as the first of a frame.
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  // Page-size strap brought onto the link clock.
  always_ff @(posedge link.sck or negedge rst_n) begin
    if (!rst_n) begin
      bin_s1 <= 1'b0;
      bin_s2 <= 1'b0;
    end else begin
      bin_s1 <= binary_pages;
      bin_s2 <= bin_s1;
    end
  end

  // Deserialiser: opcode, three address bytes, then data bytes.
  always_ff @(posedge link.sck or negedge rst_n) begin
    if (!rst_n) begin
      phase     <= 3'd0;
      hdr       <= 3'd0;
      shreg     <= 7'h00;
      opcode    <= 8'h00;
      addr      <= 24'h000000;
      have_data <= 1'b0;
      ptr       <= 9'h000;
      rx_mask   <= '0;
    end else begin
      phase <= cur_phase + 3'd1;
      shreg <= {shreg[5:0], link.mosi};
      if (fresh) begin
        have_data <= 1'b0;
        rx_mask   <= '0;
        hdr       <= 3'd0;
      end
      if (byte_end) begin
        if (cur_hdr != 3'(HDR_BYTES)) begin
          hdr <= cur_hdr + 3'd1;
        end
        unique case (cur_hdr)
          3'd0: opcode <= byte_in;
          3'd1, 3'd2: addr <= {addr[15:0], byte_in};
          3'd3: begin
            addr <= {addr[15:0], byte_in};
            ptr  <= bin_s2 ? {1'b0, byte_in} : {addr[0], byte_in};
          end
          default: begin
            rx_mask[ptr] <= 1'b1;
            have_data    <= 1'b1;
            ptr          <= (ptr == sck_last) ? 9'h000 : ptr + 9'd1;
          end
        endcase
      end
    end
  end

  // Received data lands in the buffer named by the opcode.
  always_ff @(posedge link.sck) begin
    if (data_end) begin
      rx_buf[opcode[0]][ptr] <= byte_in;
    end
  end

  assign link.miso    = 1'b0;
  assign link.miso_oe = 1'b0;

  // ---------------- Core clock domain ----------------
  logic        cs_s1;
  logic        cs_s2;
  logic        cs_q;
  logic        bin_c1;
  logic        bin_c2;
  logic        fen_s1;
  logic        fen_s2;
  logic [11:0] fpg_s1;
  logic [11:0] fpg_s2;

  // Frame end and user straps pass two flip-flops each.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_s1  <= 1'b1;
      cs_s2  <= 1'b1;
      cs_q   <= 1'b1;
      bin_c1 <= 1'b0;
      bin_c2 <= 1'b0;
      fen_s1 <= 1'b0;
      fen_s2 <= 1'b0;
      fpg_s1 <= 12'h000;
      fpg_s2 <= 12'h000;
    end else begin
      cs_s1  <= link.cs_n;
      cs_s2  <= cs_s1;
      cs_q   <= cs_s2;
      bin_c1 <= binary_pages;
      bin_c2 <= bin_c1;
      fen_s1 <= fault_en;
      fen_s2 <= fen_s1;
      fpg_s1 <= fault_page;
      fpg_s2 <= fpg_s1;
    end
  end

  // Frame decode; link registers are still while chip select is high.
  wire        cs_rise   = cs_s2 & ~cs_q;
  wire        whole     = (hdr == 3'(HDR_BYTES)) && (phase == 3'd0);
  wire [11:0] pg        = bin_c2 ? addr[19:8] : addr[20:9];
  wire        is_rmw    = (opcode == OP_RMW_B1) || (opcode == OP_RMW_B2);
  wire        is_pe     = (opcode == OP_PAGE_ERASE);
  wire        is_be     = (opcode == OP_BLOCK_ERASE);
  wire        is_se     = (opcode == OP_SECTOR_ERASE);
  wire [11:0] blk_first = pg & BLOCK_MASK;
  wire        small_sec = (pg[11:8] == 4'h0);
  wire [11:0] sec_first = small_sec ? (pg[3] ? SMALL0B_FIRST : 12'h000)
                                    : {pg[11:8], 8'h00};
  wire [11:0] sec_last  = small_sec ? (pg[3] ? SECTOR_SPAN : SMALL0A_LAST)
                                    : {pg[11:8], 8'hff};
  wire [11:0] rng_first = is_be ? blk_first : (is_se ? sec_first : pg);
  wire [11:0] rng_last  = is_be ? (blk_first | ~BLOCK_MASK) : (is_se ? sec_last : pg);
  wire [31:0] rng_limit = is_rmw ? 32'(PROG_LIMIT) : is_pe ? 32'(PE_LIMIT)
                        : is_be ? 32'(BE_LIMIT) : 32'(SE_LIMIT);
  wire        start     = cs_rise && whole && (is_rmw || is_pe || is_be || is_se);

  sfm_state_e  state;
  sfm_state_e  next_state;
  logic [11:0] cur_pg;
  logic [11:0] last_pg;
  logic [8:0]  cur_b;
  logic [31:0] op_cnt;
  logic [31:0] op_limit;
  logic        sel;
  logic        busy;
  logic [7:0]  wbuf [PAGE_STD];
  logic [7:0]  main_mem [NUM_PAGES * PAGE_STD];

  // Sweep bookkeeping shared by every phase of an operation.
  wire        rmw_run   = (state == SFM_LOAD) || (state == SFM_MERGE) || (state == SFM_PROG);
  wire [8:0]  b_last    = (rmw_run && bin_c2) ? 9'(PAGE_BIN - 1) : 9'(PAGE_STD - 1);
  wire        page_end  = (cur_b == b_last);
  wire        sweep_end = page_end && (cur_pg == last_pg);
  wire        writing   = (state == SFM_PROG) || (state == SFM_ERASE);
  wire        bad_byte  = writing && fen_s2 && (cur_pg == fpg_s2);
  wire        timeout   = (op_cnt >= op_limit) && (state != SFM_IDLE) && (state != SFM_DONE);
  wire [FLAT_W-1:0] here = flat(cur_pg, cur_b);

  // Phase sequence: load, merge, program for modify; single erase sweep.
  always_comb begin
    next_state = state;
    unique case (state)
      SFM_IDLE:  if (start) next_state = is_rmw ? SFM_LOAD : SFM_ERASE;
      SFM_LOAD:  if (sweep_end) next_state = SFM_MERGE;
      SFM_MERGE: if (sweep_end) next_state = SFM_PROG;
      SFM_PROG:  if (sweep_end) next_state = SFM_DONE;
      SFM_ERASE: if (sweep_end) next_state = SFM_DONE;
      SFM_DONE:  next_state = SFM_IDLE;
      default:   next_state = SFM_IDLE;
    endcase
    if (timeout) begin
      next_state = SFM_DONE;
    end
  end

  // Operation control, busy and the fail flag.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state                   <= SFM_IDLE;
      cur_pg                  <= 12'h000;
      last_pg                 <= 12'h000;
      cur_b                   <= 9'h000;
      op_cnt                  <= 32'h00000000;
      op_limit                <= 32'h00000001;
      sel                     <= 1'b0;
      busy                    <= 1'b0;
      ready_busy              <= 1'b1;
      erase_program_fail_flag <= 1'b0;
    end else begin
      state <= next_state;
      if (state == SFM_IDLE) begin
        if (start) begin
          cur_pg                  <= rng_first;
          last_pg                 <= rng_last;
          cur_b                   <= 9'h000;
          op_cnt                  <= 32'h00000000;
          op_limit                <= rng_limit;
          sel                     <= opcode[0];
          busy                    <= 1'b1;
          ready_busy              <= 1'b0;
          erase_program_fail_flag <= 1'b0;
        end
      end else if (state == SFM_DONE) begin
        busy       <= 1'b0;
        ready_busy <= 1'b1;
      end else begin
        op_cnt <= op_cnt + 32'd1;
        if (bad_byte || timeout) begin
          erase_program_fail_flag <= 1'b1;
        end
        if (sweep_end) begin
          cur_pg <= (state == SFM_ERASE) ? cur_pg : last_pg;
          cur_b  <= 9'h000;
          if (state == SFM_LOAD || state == SFM_MERGE) begin
            cur_pg <= last_pg;
          end
        end else if (page_end) begin
          cur_pg <= cur_pg + 12'd1;
          cur_b  <= 9'h000;
        end else begin
          cur_b <= cur_b + 9'd1;
        end
      end
    end
  end

  assign link.busy = busy;

  // Work buffer: page copy, then overwrite with received bytes only.
  always_ff @(posedge core_clk) begin
    if (state == SFM_LOAD) begin
      wbuf[cur_b] <= main_mem[here];
    end else if (state == SFM_MERGE && rx_mask[cur_b]) begin
      wbuf[cur_b] <= rx_buf[sel][cur_b];
    end
  end

  // Array writes; a faulty page keeps its old bytes and flags failure.
  always_ff @(posedge core_clk) begin
    if (writing && !bad_byte && !timeout) begin
      main_mem[here] <= (state == SFM_ERASE) ? ERASED_BYTE : wbuf[cur_b];
    end
  end
endmodule : sfm_dev

// File: hw/sfm_host.sv
`timescale 1ns/10ps
module sfm_host #(
  parameter int HALF_DIV = 1
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  sfm_link_if.host         link,
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_opcode,
  input  wire logic [23:0] cmd_addr,
  input  wire logic [8:0]  cmd_len,
  input  wire logic [2:0]  cmd_cut,
  output logic             cmd_ready,
  input  wire logic        wr_valid,
  input  wire logic [7:0]  wr_data,
  output logic             wr_ready,
  output logic             dev_busy
);
  import sfm_pkg::*;

  typedef enum logic [1:0] {
    SFMH_IDLE  = 2'b00,
    SFMH_SHIFT = 2'b01,
    SFMH_CSUP  = 2'b11
  } sfmh_state_e;

  if (HALF_DIV < 1 || HALF_DIV > 255) begin : g_chk
    $error("sfm_host: HALF_DIV must be 1 to 255");
  end

  sfmh_state_e state;
  logic        sck;
  logic        cs_n;
  logic        mosi;
  logic        busy_s1;
  logic [7:0]  div;
  logic [6:0]  sh;
  logic [2:0]  bit_pos;
  logic [9:0]  byte_no;
  logic [12:0] total;
  logic [12:0] sent;
  logic [9:0]  data_left;
  logic [23:0] addr;
  logic [7:0]  hold;
  logic        hold_full;
  logic [4:0]  wait_cnt;

  // Frame bookkeeping: next byte source, stall and data handshake.
  wire        take      = (state == SFMH_IDLE) && cmd_valid && cmd_ready;
  wire        tick      = (div == 8'(HALF_DIV - 1));
  wire        next_data = (byte_no >= 10'd2) && (byte_no != 10'h3ff);
  wire        last_bit  = (sent + 13'd1 == total);
  wire        stall     = (bit_pos == 3'd7) && next_data && !hold_full;
  wire        fall      = (state == SFMH_SHIFT) && tick && sck && !last_bit && !stall;
  wire        consume   = fall && (bit_pos == 3'd7) && next_data;
  wire        fetch     = wr_valid && wr_ready;
  wire        next_hold = (hold_full && !consume) || fetch;
  wire [9:0]  next_left = data_left - (fetch ? 10'd1 : 10'd0);
  wire [7:0]  nbyte     = (byte_no == 10'h3ff) ? addr[23:16] :
                          (byte_no == 10'd0)   ? addr[15:8]  :
                          (byte_no == 10'd1)   ? addr[7:0]   : hold;
  wire [12:0] frame_bits = 13'((HDR_BYTES + 32'(cmd_len)) * 8 + 32'(cmd_cut));

  // Clock divider, mode-0 shifting and chip select framing.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= SFMH_IDLE;
      sck       <= 1'b0;
      cs_n      <= 1'b1;
      mosi      <= 1'b0;
      busy_s1   <= 1'b0;
      dev_busy  <= 1'b0;
      div       <= 8'h00;
      sh        <= 7'h00;
      bit_pos   <= 3'd0;
      byte_no   <= 10'h000;
      total     <= 13'h0000;
      sent      <= 13'h0000;
      data_left <= 10'h000;
      addr      <= 24'h000000;
      hold      <= 8'h00;
      hold_full <= 1'b0;
      wait_cnt  <= 5'd0;
      cmd_ready <= 1'b0;
      wr_ready  <= 1'b0;
    end else begin
      busy_s1   <= link.busy;
      dev_busy  <= busy_s1;
      cmd_ready <= (state == SFMH_IDLE) && !take && !dev_busy;
      hold_full <= next_hold;
      wr_ready  <= (state == SFMH_SHIFT) && !next_hold && (next_left != 10'd0);
      if (fetch) begin
        hold      <= wr_data;
        data_left <= next_left;
      end
      unique case (state)
        SFMH_IDLE: if (take) begin
          state     <= SFMH_SHIFT;
          cs_n      <= 1'b0;
          mosi      <= cmd_opcode[7];
          sh        <= cmd_opcode[6:0];
          addr      <= cmd_addr;
          bit_pos   <= 3'd0;
          byte_no   <= 10'h3ff;
          total     <= frame_bits;
          sent      <= 13'h0000;
          data_left <= {1'b0, cmd_len} + ((cmd_cut != 3'd0) ? 10'd1 : 10'd0);
          div       <= 8'h00;
        end
        SFMH_SHIFT: begin
          div <= tick ? 8'h00 : div + 8'd1;
          if (tick && !sck) begin
            sck <= 1'b1;
          end else if (tick && last_bit) begin
            sck      <= 1'b0;
            cs_n     <= 1'b1;
            wait_cnt <= 5'd0;
            state    <= SFMH_CSUP;
          end else if (fall) begin
            sck  <= 1'b0;
            sent <= sent + 13'd1;
            if (bit_pos == 3'd7) begin
              mosi    <= nbyte[7];
              sh      <= nbyte[6:0];
              byte_no <= byte_no + 10'd1;
              bit_pos <= 3'd0;
            end else begin
              mosi    <= sh[6];
              sh      <= {sh[5:0], 1'b0};
              bit_pos <= bit_pos + 3'd1;
            end
          end
        end
        SFMH_CSUP: begin
          wait_cnt <= wait_cnt + 5'd1;
          if (wait_cnt == CS_HIGH_CYC) begin
            state <= SFMH_IDLE;
          end
        end
        default: state <= SFMH_IDLE;
      endcase
    end
  end

  assign link.sck  = sck;
  assign link.cs_n = cs_n;
  assign link.mosi = mosi;
endmodule : sfm_host

// File: verification/sfm_sva.sv
`timescale 1ns/10ps
module sfm_sva #(
  parameter int MAX_BUSY = 3100
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic busy
);
  logic [11:0] busy_len;
  logic [3:0]  since_cs;
  logic [2:0]  bit_mod;
  logic        sck_q;
  wire         sck_rise = sck && !sck_q && !cs_n;
  wire         cs_old   = cs_n && (since_cs != 4'h0);

  // Busy run length, cycles since the frame ended and frame bits modulo eight.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_len <= '0;
      since_cs <= 4'hf;
      bit_mod  <= '0;
      sck_q    <= 1'b0;
    end else begin
      busy_len <= busy ? busy_len + 12'h001 : 12'h000;
      since_cs <= !cs_n ? 4'h0 : ((since_cs == 4'hf) ? since_cs : since_cs + 4'h1);
      bit_mod  <= cs_old ? 3'h0 : bit_mod + {2'b00, sck_rise};
      sck_q    <= sck;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_sck_idle_low: assert property (cs_n |-> !sck)
    else $error("link clock moved outside a frame");
  a_mosi_held_high: assert property (sck && !cs_n |-> $stable(mosi))
    else $error("serial data changed while the link clock was high");
  a_cs_guard_time: assert property ($rose(cs_n) |-> cs_n [*8])
    else $error("new frame started too soon");
  a_busy_after_frame: assert property ($rose(busy) |-> since_cs inside {[4'h2:4'h7]})
    else $error("busy rose without a recent frame end");
  a_no_frame_busy: assert property (busy |-> cs_n)
    else $error("frame sent while the device was busy");
  a_busy_bounded: assert property (busy |-> busy_len <= MAX_BUSY)
    else $error("busy lasted beyond the time limit");
  a_busy_min_run: assert property ($rose(busy) |-> busy [*8])
    else $error("busy pulse too short for any operation");
  a_cut_aborts: assert property ($rose(cs_n) && bit_mod != 3'h0 |-> !busy [*8])
    else $error("partial byte frame started an operation");
endmodule : sfm_sva

// File: verification/testbench.sv
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; $display("Error at %0t: got %h exp %h", $time, g, e); end end
module testbench;
  import sfm_pkg::*;
  localparam int SE = 3000;
  logic        core_clk, rst_n, binary_pages, fault_en, cmd_valid, wr_valid;
  logic        ready_busy, fail, cmd_ready, wr_ready, dev_busy;
  logic [11:0] fault_page;
  logic [7:0]  cmd_opcode, wr_data;
  logic [23:0] cmd_addr;
  logic [8:0]  cmd_len;
  logic [2:0]  cmd_cut;
  logic [31:0] hdr;
  int          error_cnt, n_compared, cyc, nbits;

  sfm_link_if link ();
  sfm_dev #(.PROG_LIMIT(2000), .PE_LIMIT(2000), .BE_LIMIT(3000), .SE_LIMIT(SE)) i_sfm_dev (
    .core_clk(core_clk), .rst_n(rst_n), .link(link), .binary_pages(binary_pages),
    .fault_en(fault_en), .fault_page(fault_page), .ready_busy(ready_busy),
    .erase_program_fail_flag(fail));
  sfm_host i_sfm_host (
    .core_clk(core_clk), .rst_n(rst_n), .link(link), .cmd_valid(cmd_valid),
    .cmd_opcode(cmd_opcode), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_cut(cmd_cut),
    .cmd_ready(cmd_ready), .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready),
    .dev_busy(dev_busy));
  sfm_sva #(.MAX_BUSY(SE + 20)) i_sfm_sva (
    .core_clk(core_clk), .rst_n(rst_n), .sck(link.sck), .cs_n(link.cs_n),
    .mosi(link.mosi), .busy(link.busy));

  // The core clock runs at 40 MHz.
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Frame bits are counted and the header captured at each link clock rise.
  always @(negedge link.cs_n) nbits = 0;
  always @(posedge link.sck) begin
    if (!link.cs_n) begin
      if (nbits < 32) hdr = {hdr[30:0], link.mosi};
      nbits++;
    end
  end

  // A hung run is cut short and counted as a mismatch.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  task automatic do_reset(input logic bin);
    @(posedge core_clk);
    rst_n <= 1'b0;
    binary_pages <= bin;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask : do_reset

  // One frame, then the busy length and the fail flag; hi of zero means refused.
  task automatic do_op(input logic [7:0] op, input logic [23:0] addr, input int len,
                       input int cut, input logic fen, input logic [11:0] fpg,
                       input int lo, input int hi, input logic efail);
    int k;
    int dur;
    @(posedge core_clk);
    fault_en <= fen;
    fault_page <= fpg;
    cmd_opcode <= op;
    cmd_addr <= addr;
    cmd_len <= len[8:0];
    cmd_cut <= cut[2:0];
    cmd_valid <= 1'b1;
    k = 0;
    do begin @(posedge core_clk); k++; end while (cmd_ready !== 1'b1 && k < 300);
    cmd_valid <= 1'b0;
    for (int i = 0; i < len + (cut != 0); i++) begin
      wr_data <= 8'ha0 + i[7:0];
      wr_valid <= 1'b1;
      k = 0;
      do begin @(posedge core_clk); k++; end while (wr_ready !== 1'b1 && k < 100);
    end
    wr_valid <= 1'b0;
    k = 0;
    while (link.cs_n !== 1'b0 && k < 50) begin @(posedge core_clk); k++; end
    while (link.cs_n !== 1'b1 && k < 6000) begin @(posedge core_clk); k++; end
    `CHK(hdr, {op, addr})
    `CHK(nbits, 32 + 8 * len + cut)
    k = 0;
    while (link.busy !== 1'b1 && k < 12) begin @(posedge core_clk); k++; end
    if (hi == 0) begin
      `CHK(link.busy, 1'b0)
    end else begin
      `CHK(ready_busy, 1'b0)
      dur = 0;
      while (link.busy === 1'b1 && dur < hi + 50) begin @(posedge core_clk); dur++; end
      `CHK(dur >= lo && dur <= hi, 1'b1)
      @(posedge core_clk);
      `CHK(ready_busy, 1'b1)
      `CHK(dev_busy, 1'b1)
    end
    `CHK(fail, efail)
  endtask : do_op

  task automatic t_page_erase();
    do_op(OP_PAGE_ERASE, {3'h5, 12'h005, 9'h1ab}, 0, 0, 0, 12'h005, 264, 300, 0);
    do_op(OP_PAGE_ERASE, {3'h2, 12'h005, 9'h0f0}, 0, 0, 1, 12'h005, 264, 300, 1);
    do_op(OP_PAGE_ERASE, {3'h0, 12'h006, 9'h000}, 0, 0, 1, 12'h005, 264, 300, 0);
    `CHK(i_sfm_dev.main_mem[6 * PAGE_STD + 100], 8'hff)
  endtask : t_page_erase

  task automatic t_abort();
    do_op(OP_RMW_B1, {3'h0, 12'h005, 9'd10}, 1, 3, 1, 12'h005, 0, 0, 0);
  endtask : t_abort

  task automatic t_rmw();
    do_op(OP_RMW_B1, {3'h0, 12'h005, 9'd262}, 4, 0, 0, 12'h005, 792, 900, 0);
    do_op(OP_RMW_B2, {3'h7, 12'h005, 9'd0}, 264, 0, 1, 12'h005, 792, 900, 1);
    do_op(OP_RMW_B1, {3'h0, 12'h006, 9'd0}, 1, 0, 1, 12'h005, 792, 900, 0);
    `CHK(i_sfm_dev.main_mem[5 * PAGE_STD + 262], 8'ha0)
    `CHK(i_sfm_dev.main_mem[5 * PAGE_STD + 0], 8'ha2)
    `CHK(i_sfm_dev.main_mem[5 * PAGE_STD + 1], 8'ha3)
    `CHK(i_sfm_dev.main_mem[5 * PAGE_STD + 2], 8'hff)
    `CHK(i_sfm_dev.main_mem[6 * PAGE_STD + 0], 8'ha0)
    `CHK(i_sfm_dev.main_mem[6 * PAGE_STD + 1], 8'hff)
  endtask : t_rmw

  task automatic t_rewrite();
    do_op(OP_RMW_B2, {3'h0, 12'h005, 9'd0}, 0, 0, 1, 12'h005, 264, 2000, 1);
  endtask : t_rewrite

  task automatic t_block();
    do_op(OP_BLOCK_ERASE, {3'h7, 12'h00a, 9'h1ff}, 0, 0, 1, 12'h00c, 2112, 2200, 1);
    do_op(OP_BLOCK_ERASE, {3'h0, 12'h00f, 9'h000}, 0, 0, 1, 12'h010, 2112, 2200, 0);
    `CHK(i_sfm_dev.main_mem[12 * PAGE_STD + 7], 8'hff)
  endtask : t_block

  task automatic t_sector();
    do_op(OP_SECTOR_ERASE, {3'h0, 12'h003, 9'h0}, 0, 0, 1, 12'h005, 2112, 2200, 1);
    `CHK(i_sfm_dev.main_mem[5 * PAGE_STD + 0], 8'ha2)
    `CHK(i_sfm_dev.main_mem[6 * PAGE_STD + 0], 8'hff)
    do_op(OP_SECTOR_ERASE, {3'h0, 12'h007, 9'h0}, 0, 0, 1, 12'h008, 2112, 2200, 0);
    `CHK(i_sfm_dev.main_mem[5 * PAGE_STD + 0], 8'hff)
    do_op(OP_SECTOR_ERASE, {3'h0, 12'h5a3, 9'h0}, 0, 0, 0, 12'h000, SE - 5, SE + 10, 1);
    `CHK(i_sfm_dev.main_mem[1280 * PAGE_STD + 3], 8'hff)
  endtask : t_sector

  // Binary pages are chosen under a second reset.
  task automatic t_binary();
    do_reset(1'b1);
    do_op(OP_PAGE_ERASE, {4'hf, 12'h007, 8'h33}, 0, 0, 1, 12'h007, 256, 300, 1);
    do_op(OP_RMW_B1, {4'h0, 12'h007, 8'd254}, 4, 0, 1, 12'h007, 768, 900, 1);
    do_op(OP_SECTOR_ERASE, {4'h0, 12'h002, 8'h0}, 0, 0, 1, 12'h004, 2048, 2200, 1);
  endtask : t_binary

  // Inputs start defined and reset is held for three cycles.
  initial begin
    rst_n = 1'b0;
    binary_pages = 1'b0;
    fault_en = 1'b0;
    fault_page = 12'h000;
    cmd_valid = 1'b0;
    cmd_opcode = 8'h00;
    cmd_addr = 24'h000000;
    cmd_len = 9'h000;
    cmd_cut = 3'h0;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    error_cnt = 0;
    n_compared = 0;
    cyc = 0;
    nbits = 0;
    do_reset(1'b0);
    t_page_erase();
    t_abort();
    t_rmw();
    t_rewrite();
    t_block();
    t_sector();
    t_binary();
    wrap_up();
  end
endmodule : testbench
